/* hw/ssf_top.sv */
// Data path and status of a synchronous serial adapter: sync pattern, queues, status bits.
// Assumes an outside bit serializer that trades whole words with toggle handshakes.
//
// What this block does
// - Hold an 8-bit sync pattern for alignment, fill stripping and fill insertion.
// - Load sync pattern only on selected write with select bits second=1, first=0.
// - External sync mode skips alignment; pattern still matches and fills.
// - Host may rewrite pattern after first match; next character uses new value.
// - Match mode, not inhibited: match output high one bit time after match.
// - Sync fill carries parity only in 9-bit format; 8, 7 or 6 bits otherwise.
// - Alignment sync characters are always discarded without parity check.
// - With strip set, received pattern characters are dropped, unchecked.
// - With strip clear, pattern characters are queued and checked if parity on.
// - Receive queue: three 8-bit stages with flags, advancing on bus strobes.
// - Overrun overwrites stage one; flag holds until status read then data read, or receiver reset.
// - Unused data bits and parity position read back as zero.
// - Transmit queue: three stages; unused bits ignored; parity made internally.
// - Underflow sends pattern, recording status and pulsing output, or all ones without either.
// - Status is 8-bit read-only; reading it only arms the status-then-data read pair.
// - Receive-available: stage 3 full, or stages 2 and 3 in double mode.
// - Transmit-room: stage 1 empty, or stages 1 and 2 in double mode.
// - Transmitter reset inhibits room, empties queue, allows preloading three.
// - High send-permit inhibits room in internal sync modes only; never empties.
// - Carrier bit latches rising edge; cleared by read pair or receiver reset.
// - Send-permit bit latches rising edge; cleared by clear command or reset.
// - Byte-mode bit set means single-byte meaning, clear means double-byte.
// - Underflow status bit in fill mode; cleared by clear command or reset.
`timescale 1ns/1ps
module ssf_top (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic bus_strobe_in,
	input wire logic chip_select_in,
	input wire logic register_select_in,
	input wire logic read_not_write_in,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe_out,
	input wire logic carrier_detect_input_in,
	input wire logic send_permit_in,
	input wire logic rx_clk_in,
	input wire logic [8:0] rx_word_in,
	input wire logic rx_word_tgl_in,
	input wire logic tx_clk_in,
	input wire logic tx_req_tgl_in,
	output logic [8:0] tx_word_out,
	output logic [3:0] tx_len_out,
	output logic match_or_terminal_ready_out,
	output logic underflow_out,
	output logic rx_aligned_out
);
	logic [26:0] sy1_ff, sy2_ff;
	logic [6:0] ed_ff;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sy1_ff <= '0;
			sy2_ff <= '0;
			ed_ff <= '0;
		end else begin
			sy1_ff <= {bus_strobe_in, chip_select_in, register_select_in, read_not_write_in,
				data_in, rx_clk_in, tx_clk_in, carrier_detect_input_in, send_permit_in,
				rx_word_in, rx_word_tgl_in, tx_req_tgl_in};
			sy2_ff <= sy1_ff;
			ed_ff <= {sy2_ff[26], sy2_ff[14:11], sy2_ff[1:0]};
		end
	end

	logic e_s, cs_s, regsel_s, rw_s, rxclk_s, txclk_s, car_s, cts_s;
	logic [7:0] dat_s;
	logic [8:0] rxw_s;
	assign e_s = sy2_ff[26];
	assign cs_s = sy2_ff[25];
	assign regsel_s = sy2_ff[24];
	assign rw_s = sy2_ff[23];
	assign dat_s = sy2_ff[22:15];
	assign rxclk_s = sy2_ff[14];
	assign txclk_s = sy2_ff[13];
	assign car_s = sy2_ff[12];
	assign cts_s = sy2_ff[11];
	assign rxw_s = sy2_ff[10:2];

	logic e_rise, e_fall, rxclk_fall, txclk_fall, car_rise, cts_rise, rx_ev, tx_ev;
	assign e_rise = e_s & ~ed_ff[6];
	assign e_fall = ~e_s & ed_ff[6];
	assign rxclk_fall = ~rxclk_s & ed_ff[5];
	assign txclk_fall = ~txclk_s & ed_ff[4];
	assign car_rise = car_s & ~ed_ff[3];
	assign cts_rise = cts_s & ~ed_ff[2];
	assign rx_ev = sy2_ff[1] ^ ed_ff[1];
	assign tx_ev = sy2_ff[0] ^ ed_ff[0];

	// Control and status registers
	logic [7:0] c1_ff, c2_ff, sync_ff, dout_ff, nxt_c1, nxt_c2, nxt_sync, nxt_dout;
	logic [1:0] c3_ff, nxt_c3;
	logic oe_ff, seen_ff, ovr_ff, car_lat_ff, cts_lat_ff, uf_ff;
	logic nxt_oe, nxt_seen, nxt_ovr, nxt_car_lat, nxt_cts_lat, nxt_uf;

	// Bus accesses take effect on the strobe's falling edge, when write data is settled
	logic wr, rd, wr_c1, wr_c2, wr_c3, wr_sync, wr_txq, rd_st, rd_rx, pair;
	logic [1:0] sel;
	assign sel = c1_ff[ssf_pkg::C1_SEL_LSB +: 2];
	assign wr = e_fall & cs_s & ~rw_s;
	assign rd = e_fall & cs_s & rw_s;
	assign wr_c1 = wr & ~regsel_s;
	assign wr_c2 = wr & regsel_s & (sel == ssf_pkg::SEL_CTL2);
	assign wr_c3 = wr & regsel_s & (sel == ssf_pkg::SEL_CTL3);
	assign wr_sync = wr & regsel_s & (sel == ssf_pkg::SEL_SYNC);
	assign wr_txq = wr & regsel_s & (sel == ssf_pkg::SEL_TXQ);
	assign rd_st = rd & ~regsel_s;
	assign rd_rx = rd & regsel_s;
	assign pair = rd_rx & seen_ff;

	logic rxrst, txrst, ext_sync;
	logic [2:0] ws;
	logic [3:0] dbits, total;
	logic [8:0] dmask, tmask;
	assign rxrst = c1_ff[ssf_pkg::C1_RX_RST];
	assign txrst = c1_ff[ssf_pkg::C1_TX_RST];
	assign ext_sync = c3_ff[ssf_pkg::C3_EXT_SYNC];
	assign ws = c2_ff[ssf_pkg::C2_WS_LSB +: 3];
	assign dbits = ssf_pkg::fmt_data_bits(ws);
	assign total = ssf_pkg::fmt_total(ws);
	assign dmask = ssf_pkg::fmt_mask(dbits);
	assign tmask = ssf_pkg::fmt_mask(total);

	// Receive side word decode
	ssf_pkg::ssf_align_t align_ff, nxt_align;
	logic match, rx_keep, rx_perr, ovr_set;
	logic [8:0] smask;
	logic [2:0] rx_full, tx_full;
	logic [8:0] rx_head;
	logic [7:0] tx_head;
	// Pattern compares on its own width: 8 bits in 9-bit format, else the whole word
	assign smask = (total == 4'h9) ? ssf_pkg::fmt_mask(4'h8) : tmask;
	assign match = ((rxw_s ^ {1'b0, sync_ff}) & smask) == 9'h000;
	assign rx_keep = rx_ev & ~rxrst & (align_ff == ssf_pkg::ALIGN_LOCK)
		& ~(c1_ff[ssf_pkg::C1_STRIP] & match);
	// even parity over data and parity bit
	assign rx_perr = ws[2] & (^(rxw_s & tmask));
	// overrun only if the full first stage cannot move on in this cycle
	assign ovr_set = rx_keep & rx_full[0] & ~(e_fall & ~rx_full[1]);

	ssf_fifo3 #(.W(9)) u_rxq (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.clear_in(rxrst),
		.shift_in(e_fall),
		.load_in(rx_keep),
		.load_data_in({rx_perr, rxw_s[7:0] & dmask[7:0]}),
		.pop_in(rd_rx),
		.full_out(rx_full),
		.head_out(rx_head)
	);

	// Transmit side service
	logic tx_serve, tx_pop, uf_ev, uf_set, tx_par;
	assign tx_serve = tx_ev & ~txrst;
	assign tx_pop = tx_serve & tx_full[2];
	assign uf_ev = tx_serve & ~tx_full[2];
	assign uf_set = uf_ev & c2_ff[ssf_pkg::C2_TX_SYNC];
	assign tx_par = ^(tx_head & dmask[7:0]);

	ssf_fifo3 #(.W(8)) u_txq (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.clear_in(wr_c1 & dat_s[ssf_pkg::C1_TX_RST]),
		.shift_in(e_fall),
		.load_in(wr_txq),
		.load_data_in(dat_s),
		.pop_in(tx_pop),
		.full_out(tx_full),
		.head_out(tx_head)
	);

	// status is a pure function of state
	logic [7:0] status_v;
	logic one_byte, rx_avail, tx_room;
	assign one_byte = c2_ff[ssf_pkg::C2_ONE_BYTE];
	assign rx_avail = one_byte ? rx_full[2] : (rx_full[2] & rx_full[1]);
	assign tx_room = ~txrst & ~(cts_s & ~ext_sync)
		& (one_byte ? ~tx_full[0] : ~(tx_full[0] | tx_full[1]));
	always_comb begin
		status_v = 8'h00;
		status_v[ssf_pkg::ST_RX_AVAIL] = rx_avail;
		status_v[ssf_pkg::ST_TX_ROOM] = tx_room;
		status_v[ssf_pkg::ST_CARRIER] = car_lat_ff | car_s;
		status_v[ssf_pkg::ST_SEND] = cts_lat_ff | cts_s;
		status_v[ssf_pkg::ST_UF] = uf_ff;
		status_v[ssf_pkg::ST_OVR] = ovr_ff;
		status_v[ssf_pkg::ST_PERR] = rx_full[2] & rx_head[8];
	end

	always_comb begin
		nxt_c1 = wr_c1 ? dat_s : c1_ff;
		nxt_c2 = wr_c2 ? dat_s : c2_ff;
		nxt_c3 = wr_c3 ? dat_s[1:0] : c3_ff;
		nxt_sync = wr_sync ? dat_s : sync_ff;
		nxt_dout = dout_ff;
		nxt_oe = oe_ff;
		if (e_rise && cs_s && rw_s) begin
			// short words read with zeros above
			nxt_dout = regsel_s ? (rx_head[7:0] & dmask[7:0]) : status_v;
			nxt_oe = 1'b1;
		end else if (e_fall) begin
			nxt_oe = 1'b0;
		end
		nxt_seen = rd_st | (seen_ff & ~rd_rx);
		nxt_ovr = ovr_set | (ovr_ff & ~pair & ~rxrst);
		nxt_car_lat = car_rise | (car_lat_ff & ~pair & ~rxrst);
		nxt_cts_lat = cts_rise
			| (cts_lat_ff & ~(wr_c3 & dat_s[ssf_pkg::C3_CLR_SEND]) & ~txrst);
		nxt_uf = uf_set | (uf_ff & ~(wr_c3 & dat_s[ssf_pkg::C3_CLR_UF]) & ~txrst);
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			c1_ff <= ssf_pkg::C1_RST;
			c2_ff <= ssf_pkg::C2_RST;
			c3_ff <= ssf_pkg::C3_RST;
			sync_ff <= ssf_pkg::SYNC_RST;
			dout_ff <= 8'h00;
			oe_ff <= 1'b0;
			seen_ff <= 1'b0;
			ovr_ff <= 1'b0;
			car_lat_ff <= 1'b0;
			cts_lat_ff <= 1'b0;
			uf_ff <= 1'b0;
		end else begin
			c1_ff <= nxt_c1;
			c2_ff <= nxt_c2;
			c3_ff <= nxt_c3;
			sync_ff <= nxt_sync;
			dout_ff <= nxt_dout;
			oe_ff <= nxt_oe;
			seen_ff <= nxt_seen;
			ovr_ff <= nxt_ovr;
			car_lat_ff <= nxt_car_lat;
			cts_lat_ff <= nxt_cts_lat;
			uf_ff <= nxt_uf;
		end
	end

	// Receive alignment and match output
	logic match_ff, mtr_ff, aligned_ff, nxt_match, nxt_mtr, nxt_aligned;
	always_comb begin
		nxt_align = align_ff;
		if (rxrst || c1_ff[ssf_pkg::C1_CLR_SYNC]) begin
			nxt_align = ssf_pkg::ALIGN_HUNT;
		end else if (ext_sync) begin
			nxt_align = ssf_pkg::ALIGN_LOCK;
		end else if (rx_ev) begin
			// one or two pattern words align
			case (align_ff)
				ssf_pkg::ALIGN_HUNT: begin
					if (match) begin
						nxt_align = c3_ff[ssf_pkg::C3_ONE_SYNC] ? ssf_pkg::ALIGN_LOCK
							: ssf_pkg::ALIGN_ONE;
					end
				end
				ssf_pkg::ALIGN_ONE: begin
					nxt_align = match ? ssf_pkg::ALIGN_LOCK : ssf_pkg::ALIGN_HUNT;
				end
				default: begin
					nxt_align = ssf_pkg::ALIGN_LOCK;
				end
			endcase
		end
		// one bit time: held from the word edge to the next falling bit clock
		nxt_match = (rx_ev & match) | (match_ff & ~rxclk_fall);
		nxt_mtr = c2_ff[ssf_pkg::C2_MATCH_SEL] ? (nxt_match & ~c2_ff[ssf_pkg::C2_MATCH_INH])
			: ~c2_ff[ssf_pkg::C2_MATCH_INH];
		nxt_aligned = nxt_align == ssf_pkg::ALIGN_LOCK;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			align_ff <= ssf_pkg::ALIGN_HUNT;
			match_ff <= 1'b0;
			mtr_ff <= 1'b0;
			aligned_ff <= 1'b0;
		end else begin
			align_ff <= nxt_align;
			match_ff <= nxt_match;
			mtr_ff <= nxt_mtr;
			aligned_ff <= nxt_aligned;
		end
	end

	// Transmit word and underflow pulse
	logic [8:0] txw_ff, nxt_txw;
	logic [3:0] txl_ff, nxt_txl;
	logic ufo_ff, nxt_ufo;
	always_comb begin
		nxt_txw = txw_ff;
		nxt_txl = txl_ff;
		if (tx_pop) begin
			// parity generated here, placed after data
			nxt_txw = {1'b0, tx_head & dmask[7:0]} | ({8'h00, tx_par & ws[2]} << dbits);
			nxt_txl = total;
		end else if (uf_ev) begin
			nxt_txl = total;
			if (c2_ff[ssf_pkg::C2_TX_SYNC]) begin
				// fill parity only in 9-bit format
				nxt_txw = (total == 4'h9) ? {^sync_ff, sync_ff} : ({1'b0, sync_ff} & tmask);
			end else begin
				nxt_txw = tmask;
			end
		end
		// roughly one transmit clock high period
		nxt_ufo = uf_set | (ufo_ff & ~txclk_fall);
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			txw_ff <= ssf_pkg::MARK_WORD;
			txl_ff <= 4'h0;
			ufo_ff <= 1'b0;
		end else begin
			txw_ff <= nxt_txw;
			txl_ff <= nxt_txl;
			ufo_ff <= nxt_ufo;
		end
	end

	assign data_out = dout_ff;
	assign data_oe_out = oe_ff;
	assign tx_word_out = txw_ff;
	assign tx_len_out = txl_ff;
	assign match_or_terminal_ready_out = mtr_ff;
	assign underflow_out = ufo_ff;
	assign rx_aligned_out = aligned_ff;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_sync_load;
		wr_sync |=> sync_ff == $past(dat_s);
	endproperty
	a_sync_load: assert property (p_sync_load) else $error("pattern not loaded");

	property p_room_inhibit;
		(txrst || (cts_s && !ext_sync)) |-> !status_v[ssf_pkg::ST_TX_ROOM];
	endproperty
	a_room_inhibit: assert property (p_room_inhibit) else $error("room not inhibited");

	sequence s_overrun;
		rx_keep && rx_full[0] && !(e_fall && !rx_full[1]);
	endsequence
	sequence s_clear_pair;
		pair && !ovr_set;
	endsequence
	property p_ovr_set;
		s_overrun |=> ovr_ff ##1 (ovr_ff || $past(pair) || $past(rxrst));
	endproperty
	a_ovr_set: assert property (p_ovr_set) else $error("overrun not held");

	property p_ovr_clear;
		s_clear_pair |=> !ovr_ff;
	endproperty
	a_ovr_clear: assert property (p_ovr_clear) else $error("overrun not cleared");

	property p_match_pulse;
		(rx_ev && match && c2_ff[0] && !c2_ff[1] && !wr_c2) |=> match_or_terminal_ready_out;
	endproperty
	a_match_pulse: assert property (p_match_pulse) else $error("no match pulse");

	property p_strip;
		(rx_ev && match && c1_ff[ssf_pkg::C1_STRIP] && !rx_full[0]) |=> !rx_full[0];
	endproperty
	a_strip: assert property (p_strip) else $error("pattern word queued");

	property p_underflow;
		uf_set |=> underflow_out && uf_ff && tx_len_out == $past(total);
	endproperty
	a_underflow: assert property (p_underflow) else $error("underflow missed");

	property p_read_zero;
		(e_rise && cs_s && rw_s && regsel_s) |=> ({1'b0, data_out} & ~$past(dmask)) == 9'h000;
	endproperty
	a_read_zero: assert property (p_read_zero) else $error("unused bits set");

	property p_carrier;
		(car_rise && !rxrst) |=> status_v[ssf_pkg::ST_CARRIER]
			##1 (status_v[ssf_pkg::ST_CARRIER] || $past(pair) || $past(rxrst));
	endproperty
	a_carrier: assert property (p_carrier) else $error("carrier not latched");

	property p_send_latch;
		cts_rise |=> cts_lat_ff;
	endproperty
	a_send_latch: assert property (p_send_latch) else $error("send-permit not latched");
endmodule

/* pkg/ssf_pkg.sv */
// Shared constants, types and format helpers for the sync serial FIFO and status block.
// Assumes a single 100 MHz clock; every pin input but the asynchronous reset is synchronised before use.
package ssf_pkg;
	// Write select held in control word 1 bits 7:6, {second, first}
	localparam logic [1:0] SEL_CTL2 = 2'h0;
	localparam logic [1:0] SEL_CTL3 = 2'h1;
	localparam logic [1:0] SEL_SYNC = 2'h2;
	localparam logic [1:0] SEL_TXQ = 2'h3;
	// Control word 1 fields
	localparam int C1_RX_RST = 0;
	localparam int C1_TX_RST = 1;
	localparam int C1_STRIP = 2;
	localparam int C1_CLR_SYNC = 3;
	localparam int C1_SEL_LSB = 6;
	// Control word 2 fields
	localparam int C2_MATCH_SEL = 0;
	localparam int C2_MATCH_INH = 1;
	localparam int C2_ONE_BYTE = 2;
	localparam int C2_WS_LSB = 3;
	localparam int C2_TX_SYNC = 6;
	// Control word 3 fields
	localparam int C3_EXT_SYNC = 0;
	localparam int C3_ONE_SYNC = 1;
	localparam int C3_CLR_SEND = 2;
	localparam int C3_CLR_UF = 3;
	// Status fields
	localparam int ST_RX_AVAIL = 0;
	localparam int ST_TX_ROOM = 1;
	localparam int ST_CARRIER = 2;
	localparam int ST_SEND = 3;
	localparam int ST_UF = 4;
	localparam int ST_OVR = 5;
	localparam int ST_PERR = 6;
	// Reset values: both section resets start asserted
	localparam logic [7:0] C1_RST = 8'h03;
	localparam logic [7:0] C2_RST = 8'h00;
	localparam logic [1:0] C3_RST = 2'h0;
	localparam logic [7:0] SYNC_RST = 8'h00;
	localparam logic [8:0] MARK_WORD = 9'h1FF;

	typedef enum logic [1:0] {ALIGN_HUNT, ALIGN_ONE, ALIGN_LOCK} ssf_align_t;

	// Format: ws[1:0] = 0/1/2 gives 6/7/8 data bits, ws[2] adds even parity
	function automatic logic [3:0] fmt_data_bits(input logic [2:0] ws);
		fmt_data_bits = (ws[1:0] == 2'h0) ? 4'h6 : ((ws[1:0] == 2'h1) ? 4'h7 : 4'h8);
	endfunction

	function automatic logic [3:0] fmt_total(input logic [2:0] ws);
		fmt_total = fmt_data_bits(ws) + {3'h0, ws[2]};
	endfunction

	function automatic logic [8:0] fmt_mask(input logic [3:0] n);
		fmt_mask = MARK_WORD >> (4'h9 - n);
	endfunction
endpackage

/* hw/ssf_fifo3.sv */
// Three-stage queue: stage 0 is filled, stage 2 is the head.
// Advances one step per strobe; a load into a full stage 0 overwrites it.
`timescale 1ns/1ps
module ssf_fifo3 #(
	parameter int W = 8
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic clear_in,
	input wire logic shift_in,
	input wire logic load_in,
	input wire logic [W-1:0] load_data_in,
	input wire logic pop_in,
	output logic [2:0] full_out,
	output logic [W-1:0] head_out
);
	logic [W-1:0] dat_ff [3];
	logic [W-1:0] nxt_dat [3];
	logic [2:0] full_ff, nxt_full;

	always_comb begin
		nxt_dat = dat_ff;
		nxt_full = full_ff;
		// Moves judged on old flags, so a word moves one stage per strobe
		if (shift_in && full_ff[1] && !full_ff[2]) begin
			nxt_dat[2] = dat_ff[1];
			nxt_full[2] = 1'b1;
			nxt_full[1] = 1'b0;
		end
		if (shift_in && full_ff[0] && !full_ff[1]) begin
			nxt_dat[1] = dat_ff[0];
			nxt_full[1] = 1'b1;
			nxt_full[0] = 1'b0;
		end
		if (pop_in) begin
			nxt_full[2] = 1'b0;
		end
		if (load_in) begin
			nxt_dat[0] = load_data_in;
			nxt_full[0] = 1'b1;
		end
		if (clear_in) begin
			nxt_full = 3'h0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dat_ff <= '{default: '0};
			full_ff <= 3'h0;
		end else begin
			dat_ff <= nxt_dat;
			full_ff <= nxt_full;
		end
	end

	assign full_out = full_ff;
	assign head_out = dat_ff[2];
endmodule

/* dv/ssf_line_model.sv */
// Serial line partner: bit clocks, received words and transmit requests by toggles.
// Assumes the bench clock; every output changes on its falling edge.
`timescale 1ns/1ps
module ssf_line_model (
	input wire logic clk_in,
	output logic rx_clk_out,
	output logic [8:0] rx_word_out,
	output logic rx_word_tgl_out,
	output logic tx_clk_out,
	output logic tx_req_tgl_out
);
	initial begin
		rx_clk_out = 1'b0;
		rx_word_out = 9'h000;
		rx_word_tgl_out = 1'b0;
		tx_clk_out = 1'b0;
		tx_req_tgl_out = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk_in);
	endtask

	// Word held steady around its toggle, then the next frame's bit clocks run
	task automatic send_word(input logic [8:0] w);
		int i;
		rx_word_out = w;
		wait_clk(5);
		rx_word_tgl_out = ~rx_word_tgl_out;
		wait_clk(5);
		for (i = 0; i < 8; i++) begin
			// Word no longer valid: a moving pattern, so stale values cannot pass
			rx_word_out = ~w ^ 9'(i);
			rx_clk_out = 1'b1;
			wait_clk(8);
			rx_clk_out = 1'b0;
			wait_clk(8);
		end
	endtask

	// Bit clock runs only for the frame that follows a request
	task automatic request_tx();
		int i;
		tx_req_tgl_out = ~tx_req_tgl_out;
		for (i = 0; i < 8; i++) begin
			tx_clk_out = 1'b1;
			wait_clk(8);
			tx_clk_out = 1'b0;
			wait_clk(8);
		end
	endtask
endmodule

/* dv/tb_top.sv */
// Self-checking bench: bus master tasks, flag model and a serial line partner.
// Assumes the design's select encoding, a 150 ns strobe and a 160 ns bit clock.
`timescale 1ns/1ps
module tb_top;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic bus_strobe = 1'b0;
	logic chip_select = 1'b0;
	logic register_select = 1'b0;
	logic read_not_write = 1'b1;
	logic [7:0] bus_data = 8'h00;
	logic carrier = 1'b0;
	logic send_permit = 1'b0;
	logic [7:0] data_out, q, p, d, t1, t2;
	logic data_oe, rx_clk, rx_tgl, tx_clk, tx_tgl, match_out, uf_out, aligned;
	logic [8:0] rx_word, tx_word;
	logic [3:0] tx_len;
	logic ovr = 1'b0, uf = 1'b0, snd = 1'b0, car = 1'b0, uf_seen = 1'b0, match_seen = 1'b0;
	logic arm = 1'b0;
	logic [7:0] rxq[$];
	int bad_count = 0, checks = 0, cycles = 0, seed = 23, i;

	always #5 clk_in = ~clk_in;

	ssf_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_strobe_in(bus_strobe),
		.chip_select_in(chip_select), .register_select_in(register_select),
		.read_not_write_in(read_not_write), .data_in(bus_data), .data_out(data_out),
		.data_oe_out(data_oe), .carrier_detect_input_in(carrier), .send_permit_in(send_permit),
		.rx_clk_in(rx_clk), .rx_word_in(rx_word), .rx_word_tgl_in(rx_tgl), .tx_clk_in(tx_clk),
		.tx_req_tgl_in(tx_tgl), .tx_word_out(tx_word), .tx_len_out(tx_len),
		.match_or_terminal_ready_out(match_out), .underflow_out(uf_out), .rx_aligned_out(aligned));

	ssf_line_model line (.clk_in(clk_in), .rx_clk_out(rx_clk), .rx_word_out(rx_word),
		.rx_word_tgl_out(rx_tgl), .tx_clk_out(tx_clk), .tx_req_tgl_out(tx_tgl));

	always @(posedge clk_in) begin
		if (uf_out === 1'b1)
			uf_seen <= 1'b1;
		// Armed once match mode is set: the ready level is high just after reset
		match_seen <= arm & (match_seen | (match_out === 1'b1));
	end

	task automatic finish_test();
		if (bad_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			finish_test();
		end
	end

	task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Request and qualifiers held for the whole strobe; read data taken before the fall
	task automatic bus(input logic r, input logic w, input logic [7:0] v, output logic [7:0] o);
		@(negedge clk_in);
		chip_select = 1'b1;
		register_select = r;
		read_not_write = w;
		bus_data = v;
		bus_strobe = 1'b1;
		repeat (15) @(negedge clk_in);
		o = data_out;
		if (w)
			check("read enable", 9'(data_oe), 9'h001);
		bus_strobe = 1'b0;
		repeat (16) @(negedge clk_in);
		chip_select = 1'b0;
		if (w)
			check("read enable off", 9'(data_oe), 9'h000);
	endtask

	// select bits in control word 1, strip kept set
	task automatic wreg(input logic [1:0] sel, input logic [7:0] v);
		bus(1'b0, 1'b0, {sel, 6'h04}, q);
		bus(1'b1, 1'b0, v, q);
	endtask

	task automatic st(input logic avail, input logic room);
		bus(1'b0, 1'b1, 8'h00, q);
		check("status", 9'(q), {3'h0, ovr, uf, snd | send_permit, car | carrier, room, avail});
	endtask

	task automatic get_data(output logic [7:0] v);
		v = 8'($random(seed));
		if (v == p)
			v = ~v;
	endtask

	initial begin
		repeat (12) @(negedge clk_in);
		rst_n_in = 1'b1;
		repeat (2) @(negedge clk_in);
		st(1'b0, 1'b0);
		// Match pulse on, single byte, 8 data bits no parity, sync fill on underflow
		wreg(ssf_pkg::SEL_CTL2, 8'h55);
		wreg(ssf_pkg::SEL_CTL3, 8'h02);
		p = 8'($random(seed));
		wreg(ssf_pkg::SEL_SYNC, p);
		st(1'b0, 1'b1);
		arm = 1'b1;
		line.send_word({1'b0, p});
		check("aligned", 9'(aligned), 9'h001);
		check("match pulse", 9'(match_seen), 9'h001);
		check("match end", 9'(match_out), 9'h000);
		for (i = 0; i < 3; i++) begin
			get_data(d);
			if (i == 1)
				d = p;
			else
				rxq.push_back(d);
			line.send_word({1'b0, d});
			st(i == 2, 1'b1);
		end
		for (i = 0; i < 2; i++) begin
			bus(1'b1, 1'b1, 8'h00, q);
			check("rx data", 9'(q), 9'(rxq.pop_front()));
			bus(1'b0, 1'b1, 8'h00, q);
			st(i == 0, 1'b1);
		end
		carrier = 1'b1;
		repeat (5) @(negedge clk_in);
		carrier = 1'b0;
		car = 1'b1;
		get_data(d);
		line.send_word({1'b0, d});
		get_data(d);
		line.send_word({1'b0, d});
		ovr = 1'b1;
		st(1'b0, 1'b1);
		st(1'b0, 1'b1);
		bus(1'b1, 1'b1, 8'h00, q);
		check("overrun data", 9'(q), 9'(d));
		ovr = 1'b0;
		car = 1'b0;
		st(1'b0, 1'b1);
		send_permit = 1'b1;
		repeat (5) @(negedge clk_in);
		snd = 1'b1;
		st(1'b0, 1'b0);
		send_permit = 1'b0;
		st(1'b0, 1'b1);
		wreg(ssf_pkg::SEL_CTL3, 8'h06);
		snd = 1'b0;
		st(1'b0, 1'b1);
		get_data(t1);
		get_data(t2);
		wreg(ssf_pkg::SEL_TXQ, t1);
		bus(1'b1, 1'b0, t2, q);
		bus(1'b0, 1'b1, 8'h00, q);
		bus(1'b0, 1'b1, 8'h00, q);
		line.request_tx();
		check("tx word 1", tx_word, 9'(t1));
		check("tx len", 9'(tx_len), 9'h008);
		// The queue only advances on strobes: one moves the second word to the head
		bus(1'b0, 1'b1, 8'h00, q);
		line.request_tx();
		check("tx word 2", tx_word, 9'(t2));
		check("early underflow", 9'(uf_seen), 9'h000);
		line.request_tx();
		uf = 1'b1;
		check("fill word", tx_word, 9'(p));
		check("fill len", 9'(tx_len), 9'h008);
		check("underflow pulse", 9'(uf_seen), 9'h001);
		st(1'b0, 1'b1);
		wreg(ssf_pkg::SEL_CTL3, 8'h0A);
		uf = 1'b0;
		st(1'b0, 1'b1);
		// External sync: send-permit no longer inhibits room, pattern still fills
		wreg(ssf_pkg::SEL_CTL3, 8'h01);
		send_permit = 1'b1;
		snd = 1'b1;
		line.request_tx();
		uf = 1'b1;
		check("ext fill", tx_word, 9'(p));
		check("ext aligned", 9'(aligned), 9'h001);
		st(1'b0, 1'b1);
		finish_test();
	end
endmodule
